// [fpu_state_word_control.sv]
// Architectural state word control for the integrated floating-point unit.
// Assumes the integer unit pulses instruction events synchronous to clock,
// and holds the eight stack registers' contents on stack_values.
module fpu_state_word_control
(
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [2:0] hburst,
   input wire logic [3:0] hprot,
   input wire logic hmastlock,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [639:0] stack_values,
   input wire logic fpu_init_instr,
   input wire logic remainder_incomplete,
   input wire logic partial_tangent_done,
   input wire logic partial_tangent_incomplete,
   input wire logic stack_fault_event,
   input wire logic stack_overflow,
   input wire logic unmasked_exception,
   input wire logic fpu_sync_instr,
   input wire logic tag_restore_instr,
   input wire logic [15:0] tag_restore_word,
   input wire logic tag_store_instr,
   output logic [15:0] tag_store_word,
   output logic dev_not_avail,
   output logic internal_fault,
   output logic external_fault_request,
   output logic [7:0] fault_vector,
   output logic affine_closure,
   output logic irq
);
   // ------------------------------------------------------------
   // Bus front end and tag classifiers
   // ------------------------------------------------------------
   logic wr_en;
   logic rd_phase;
   logic [7:0] addr;
   logic [15:0] computed_tags;
   ahb_reg_slave bus
   (
      .clock(clock),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_en(wr_en),
      .rd_phase(rd_phase),
      .addr(addr)
   );
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : classify
         tag_classifier cls
         (
            .value(stack_values[g*80 +: 80]),
            .tag(computed_tags[g*2 +: 2]) // see RULE_12
         );
      end
   endgenerate
   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   logic [15:0] ctrl_zero;
   logic [15:0] status_word;
   logic [15:0] control_word;
   logic [15:0] tag_word;
   logic [3:0] irq_status;
   logic [3:0] irq_enable;
   logic [15:0] tag_out;
   logic dna;
   logic int_fault;
   logic ext_fault;
   logic [7:0] vector;
   logic [15:0] next_ctrl_zero;
   logic [15:0] next_status_word;
   logic [15:0] next_control_word;
   logic [15:0] next_tag_word;
   logic [3:0] next_irq_status;
   logic [3:0] next_irq_enable;
   logic [15:0] next_tag_out;
   logic next_dna;
   logic next_int_fault;
   logic next_ext_fault;
   logic [7:0] next_vector;
   logic [3:0] events;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction : hit

   function automatic logic [15:0] restore_tags(input logic [15:0] incoming);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 8; i++)
         r[i*2 +: 2] = (incoming[i*2 +: 2] == fpu_state_pkg::tag_empty) ?
                       fpu_state_pkg::tag_empty : fpu_state_pkg::tag_valid;
      restore_tags = r;
   endfunction : restore_tags

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_ctrl_zero = ctrl_zero;
      next_status_word = status_word;
      next_control_word = control_word;
      next_tag_word = tag_word;
      next_irq_enable = irq_enable;
      next_tag_out = tag_out;
      next_dna = 1'b0;
      next_int_fault = 1'b0;
      next_ext_fault = 1'b0;
      next_vector = vector;
      events = 4'h0;
      // Software writes
      if (wr_en)
      begin
         if (hit(addr, fpu_state_pkg::ctrl_zero_addr))
            next_ctrl_zero = hwdata[15:0];
         if (hit(addr, fpu_state_pkg::status_word_addr))
            next_status_word = hwdata[15:0];
         if (hit(addr, fpu_state_pkg::control_word_addr))
            next_control_word = hwdata[15:0]; // see RULE_10
         if (hit(addr, fpu_state_pkg::tag_word_addr))
            next_tag_word = hwdata[15:0];
         if (hit(addr, fpu_state_pkg::irq_enable_addr))
            next_irq_enable = hwdata[3:0];
      end
      next_ctrl_zero[fpu_state_pkg::coproc_type_bit] = 1'b1; // see RULE_01
      // Device-not-available trap
      if (fpu_sync_instr && ctrl_zero[fpu_state_pkg::wait_monitor_bit]
          && ctrl_zero[fpu_state_pkg::task_switched_bit]) // see RULE_04
      begin
         next_dna = 1'b1;
         next_vector = fpu_state_pkg::dev_not_avail_vector;
         events[fpu_state_pkg::irq_dna] = 1'b1;
      end
      // Exception routing
      else if (unmasked_exception)
      begin
         if (ctrl_zero[fpu_state_pkg::internal_fault_bit]) // see RULE_02
         begin
            next_int_fault = 1'b1;
            next_vector = fpu_state_pkg::fault_vector_internal;
            events[fpu_state_pkg::irq_internal] = 1'b1;
         end
         else
         begin
            next_ext_fault = 1'b1; // see RULE_02
            events[fpu_state_pkg::irq_external] = 1'b1;
         end
      end
      // Condition codes
      if (remainder_incomplete)
      begin
         next_status_word[fpu_state_pkg::cond_0_bit] = 1'b0; // see RULE_07
         next_status_word[fpu_state_pkg::cond_1_bit] = 1'b0;
         next_status_word[fpu_state_pkg::cond_3_bit] = 1'b0;
         next_status_word[fpu_state_pkg::cond_2_bit] = 1'b1;
      end
      if (partial_tangent_done)
         next_status_word[fpu_state_pkg::cond_2_bit] = partial_tangent_incomplete; // see RULE_08
      if (stack_fault_event)
      begin
         next_status_word[fpu_state_pkg::invalid_op_bit] = 1'b1; // see RULE_09
         next_status_word[fpu_state_pkg::stack_fault_bit] = 1'b1;
         next_status_word[fpu_state_pkg::cond_1_bit] = stack_overflow;
         events[fpu_state_pkg::irq_stack] = 1'b1;
      end
      // Tag handling
      if (tag_restore_instr)
         next_tag_word = restore_tags(tag_restore_word); // see RULE_11
      if (tag_store_instr)
      begin
         for (int i = 0; i < 8; i++) // see RULE_15
            next_tag_out[i*2 +: 2] = (tag_word[i*2 +: 2] == fpu_state_pkg::tag_empty) ?
                                     fpu_state_pkg::tag_empty :
                                     computed_tags[i*2 +: 2]; // see RULE_13
      end
      if (fpu_init_instr)
      begin
         next_status_word = 16'h0000; // see RULE_06
         next_control_word = fpu_state_pkg::control_word_reset;
         next_tag_word = fpu_state_pkg::tag_word_reset;
      end
      // Sticky status: set wins over clear
      next_irq_status = irq_status;
      if (wr_en && hit(addr, fpu_state_pkg::irq_clear_addr))
         next_irq_status = irq_status & ~hwdata[3:0];
      next_irq_status = next_irq_status | events;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Architectural state words
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ctrl_zero <= fpu_state_pkg::ctrl_zero_reset; // see RULE_03
         status_word <= 16'h0000; // see RULE_06
         control_word <= fpu_state_pkg::control_word_reset;
         tag_word <= fpu_state_pkg::tag_word_reset;
      end
      else
      begin
         ctrl_zero <= next_ctrl_zero;
         status_word <= next_status_word;
         control_word <= next_control_word;
         tag_word <= next_tag_word;
      end
   end

   // Interrupt status and enable
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         irq_status <= 4'h0;
         irq_enable <= 4'h0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
      end
   end

   // Trap pulses, vector and stored tag word
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tag_out <= 16'h0000;
         dna <= 1'b0;
         int_fault <= 1'b0;
         ext_fault <= 1'b0;
         vector <= 8'h00;
      end
      else
      begin
         tag_out <= next_tag_out;
         dna <= next_dna;
         int_fault <= next_int_fault;
         ext_fault <= next_ext_fault;
         vector <= next_vector;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb
   begin
      hrdata = 32'h00000000;
      if (rd_phase)
      begin
         if (hit(addr, fpu_state_pkg::ctrl_zero_addr))
            hrdata = {16'h0000, ctrl_zero};
         else if (hit(addr, fpu_state_pkg::status_word_addr))
            hrdata = {16'h0000, status_word};
         else if (hit(addr, fpu_state_pkg::control_word_addr))
            hrdata = {16'h0000, control_word};
         else if (hit(addr, fpu_state_pkg::tag_word_addr))
            hrdata = {16'h0000, tag_word};
         else if (hit(addr, fpu_state_pkg::irq_status_addr))
            hrdata = {28'h0000000, irq_status};
         else if (hit(addr, fpu_state_pkg::irq_enable_addr))
            hrdata = {28'h0000000, irq_enable};
         else if (hit(addr, fpu_state_pkg::fault_info_addr))
            hrdata = {16'h0000, tag_out};
         else
            hrdata = 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign tag_store_word = tag_out;
   assign dev_not_avail = dna;
   assign internal_fault = int_fault;
   assign external_fault_request = ext_fault;
   assign fault_vector = vector;
   assign affine_closure = 1'b1; // see RULE_10
   assign irq = |(irq_status & irq_enable);
endmodule : fpu_state_word_control

// [fpu_state_pkg.sv]
// Constants for the floating-point state word control block.
// Assumes a single 40 MHz core clock and an AHB-Lite register bus.
// Overview of operation
// RULE_01: Coprocessor type flag always reads one.
// RULE_02: Fault flag set: vector 16, else external.
// RULE_03: Reset clears internal fault report flag.
// RULE_04: Monitor and task switched trap sync, vector 7.
// RULE_05: Software should keep wait monitor flag set.
// RULE_06: Init and reset clear four condition flags.
// RULE_07: Incomplete remainder clears flags zero, one, three.
// RULE_08: Flag two marks incomplete partial tangent.
// RULE_09: Stack fault sets invalid, stack fault, flag one; the code copies stack_overflow into flag one, clearing it on underflow.
// RULE_10: Infinity bit writable, arithmetic always affine.
// RULE_11: Loaded tag 11 empty, others non-empty.
// RULE_12: Non-empty registers classified from contents.
// RULE_13: Store recomputes tags of non-empty registers.
// RULE_14: Unsupported formats get special tag 10B.
// RULE_15: Tag word packs eight two-bit tags in order.
package fpu_state_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ctrl_zero_addr = 8'h00;
   localparam logic [7:0] status_word_addr = 8'h04;
   localparam logic [7:0] control_word_addr = 8'h08;
   localparam logic [7:0] tag_word_addr = 8'h0c;
   localparam logic [7:0] irq_status_addr = 8'h10;
   localparam logic [7:0] irq_enable_addr = 8'h14;
   localparam logic [7:0] irq_clear_addr = 8'h18;
   localparam logic [7:0] fault_info_addr = 8'h1c;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int wait_monitor_bit = 1;
   localparam int task_switched_bit = 3;
   localparam int coproc_type_bit = 4;
   localparam int internal_fault_bit = 5;
   localparam int invalid_op_bit = 0;
   localparam int stack_fault_bit = 6;
   localparam int cond_0_bit = 8;
   localparam int cond_1_bit = 9;
   localparam int cond_2_bit = 10;
   localparam int cond_3_bit = 14;
   localparam int infinity_bit = 12;
   // ------------------------------------------------------------
   // Vectors, tags, reset values
   // ------------------------------------------------------------
   localparam logic [7:0] fault_vector_internal = 8'h10;
   localparam logic [7:0] dev_not_avail_vector = 8'h07;
   localparam logic [1:0] tag_valid = 2'h0;
   localparam logic [1:0] tag_zero = 2'h1;
   localparam logic [1:0] tag_special = 2'h2;
   localparam logic [1:0] tag_empty = 2'h3;
   localparam logic [15:0] ctrl_zero_reset = 16'h0010;
   localparam logic [15:0] control_word_reset = 16'h037f;
   localparam logic [15:0] tag_word_reset = 16'hffff;
   localparam int irq_dna = 0;
   localparam int irq_internal = 1;
   localparam int irq_external = 2;
   localparam int irq_stack = 3;
   localparam int irq_width = 4;
   typedef enum logic [1:0]
   {
      op_classify = 2'b00,
      op_restore = 2'b01,
      op_store = 2'b10
   } tag_op_t;
endpackage : fpu_state_pkg

// [tag_classifier.sv]
// Classifies one 80-bit stack register into a two-bit tag.
// Assumes extended format: sign, 15-bit exponent, explicit integer bit.
module tag_classifier
(
   input wire logic [79:0] value,
   output logic [1:0] tag
);
   logic [14:0] exponent;
   logic integer_bit;
   logic [62:0] fraction;
   assign exponent = value[78:64];
   assign integer_bit = value[63];
   assign fraction = value[62:0];
   always_comb
   begin
      if (exponent == 15'h0000)
      begin
         if (!integer_bit && fraction == 63'h0)
            tag = fpu_state_pkg::tag_zero;
         else
            tag = fpu_state_pkg::tag_special; // see RULE_14
      end
      else if (!integer_bit)
         tag = fpu_state_pkg::tag_special; // see RULE_14
      else if (exponent == 15'h7fff)
         tag = fpu_state_pkg::tag_special;
      else
         tag = fpu_state_pkg::tag_valid;
   end
endmodule : tag_classifier

// [ahb_reg_slave.sv]
// AHB-Lite slave front end: captures the address phase for the core.
// Assumes one master; zero wait states; response always OKAY.
module ahb_reg_slave
(
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic wr_en,
   output logic rd_phase,
   output logic [7:0] addr
);
   logic wr_pend;
   logic rd_pend;
   logic [7:0] addr_q;
   logic next_wr_pend;
   logic next_rd_pend;
   logic [7:0] next_addr_q;
   logic take;
   assign take = hsel && hready && htrans[1] && hsize == 3'h2;
   always_comb
   begin
      next_wr_pend = take && hwrite;
      next_rd_pend = take && !hwrite;
      next_addr_q = take ? haddr[7:0] : addr_q;
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= 8'h00;
      end
      else
      begin
         wr_pend <= next_wr_pend;
         rd_pend <= next_rd_pend;
         addr_q <= next_addr_q;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_en = wr_pend;
   assign rd_phase = rd_pend;
   assign addr = addr_q;
endmodule : ahb_reg_slave

// [fpu_state_word_control_assertions.sv]
// Checker for the floating-point state word control block.
// Sees only the top module's ports; bound to it at the foot of the file.
module fpu_state_checker
(
   input wire logic clock,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic fpu_init_instr,
   input wire logic remainder_incomplete,
   input wire logic partial_tangent_done,
   input wire logic partial_tangent_incomplete,
   input wire logic stack_fault_event,
   input wire logic stack_overflow,
   input wire logic unmasked_exception,
   input wire logic fpu_sync_instr,
   input wire logic tag_store_instr,
   input wire logic [15:0] tag_store_word,
   input wire logic dev_not_avail,
   input wire logic internal_fault,
   input wire logic [7:0] fault_vector,
   input wire logic affine_closure
);
   logic rd_go;
   logic quiet;
   logic rd_ctrl;
   assign rd_go = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
   assign quiet = !(fpu_init_instr || remainder_incomplete || partial_tangent_done
                    || stack_fault_event);
   // Data phase of a control reg zero read
   always_ff @(posedge clock or posedge reset)
      if (reset)
         rd_ctrl <= 1'b0;
      else
         rd_ctrl <= rd_go && haddr[7:0] == 8'h00;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // Quiet status read address phase
   sequence rd_sq;
      rd_go && haddr[7:0] == 8'h04 && quiet;
   endsequence
   a_type_reads_one: assert property (rd_ctrl |-> hrdata[4])
      else $error("type flag read as zero");
   a_internal_vector: assert property (internal_fault |->
      $past(unmasked_exception) && fault_vector == 8'h10)
      else $error("internal fault without cause or vector");
   a_dna_vector: assert property (dev_not_avail |->
      $past(fpu_sync_instr) && fault_vector == 8'h07)
      else $error("device trap without cause or vector");
   a_affine_fixed: assert property (affine_closure)
      else $error("closure not affine");
   a_init_clears: assert property (fpu_init_instr ##1 rd_sq |=>
      hrdata[14] == 1'b0 && hrdata[10:8] == 3'h0)
      else $error("condition flags not cleared by init");
   a_rem_clears: assert property (remainder_incomplete && !fpu_init_instr
      && !stack_fault_event ##1 rd_sq |=> hrdata[9:8] == 2'h0 && !hrdata[14])
      else $error("remainder left flags set");
   a_stack_flags: assert property (stack_fault_event && !fpu_init_instr
      && !remainder_incomplete ##1 rd_sq |=>
      hrdata[0] && hrdata[6] && hrdata[9] == $past(stack_overflow, 2))
      else $error("stack fault flags wrong");
   a_tangent_flag: assert property (partial_tangent_done && !fpu_init_instr
      && !remainder_incomplete ##1 rd_sq |=>
      hrdata[10] == $past(partial_tangent_incomplete, 2))
      else $error("tangent flag wrong");
   a_store_only: assert property (!$past(tag_store_instr) |->
      $stable(tag_store_word))
      else $error("stored tag word changed without store");
   c_dna: cover property (dev_not_avail);
   c_internal: cover property (internal_fault);
   c_store: cover property (tag_store_instr ##1 1'b1);
endmodule : fpu_state_checker

bind fpu_state_word_control fpu_state_checker i_fpu_state_checker
(
   .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hrdata,
   .fpu_init_instr, .remainder_incomplete, .partial_tangent_done,
   .partial_tangent_incomplete, .stack_fault_event, .stack_overflow,
   .unmasked_exception, .fpu_sync_instr, .tag_store_instr, .tag_store_word,
   .dev_not_avail, .internal_fault, .fault_vector, .affine_closure
);

// [iu_model.sv]
// Integer execution unit model: issues instruction events to the block.
// Assumes events are one-cycle pulses changed just after a rising edge.
module iu_model
(
   input wire logic clock,
   output logic fpu_init_instr,
   output logic remainder_incomplete,
   output logic partial_tangent_done,
   output logic stack_fault_event,
   output logic unmasked_exception,
   output logic fpu_sync_instr,
   output logic tag_restore_instr,
   output logic tag_store_instr,
   output logic stack_overflow,
   output logic partial_tangent_incomplete,
   output logic [15:0] tag_restore_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ev_q = 8'h00;
   assign {fpu_init_instr, remainder_incomplete, partial_tangent_done, stack_fault_event,
      unmasked_exception, fpu_sync_instr, tag_restore_instr, tag_store_instr} = ev_q;
   initial
   begin
      stack_overflow = 1'b0;
      partial_tangent_incomplete = 1'b0;
      tag_restore_word = 16'h0;
   end
   // One event pulse; qualifiers inverted once their hold has run out
   task automatic fire(input logic [7:0] ev, input logic lvl, input logic [15:0] w);
      @(posedge clock);
      ev_q <= ev;
      stack_overflow <= lvl;
      partial_tangent_incomplete <= lvl;
      tag_restore_word <= w;
      @(posedge clock);
      ev_q <= 8'h00;
      stack_overflow <= ~lvl;
      partial_tangent_incomplete <= ~lvl;
      tag_restore_word <= ~w;
   endtask : fire
endmodule : iu_model

// [tb_fpu_state_word_control.sv]
// Self-checking bench for the floating-point state word control block.
// Assumes iu_model issues events; the bench is the AHB-Lite master.
module tb_fpu_state_word_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [639:0] stack_values = '0;
   logic [31:0] hrdata;
   logic [15:0] tag_restore_word, tag_store_word;
   logic [7:0] fault_vector;
   logic hreadyout, hresp, fpu_init_instr, remainder_incomplete, partial_tangent_done;
   logic partial_tangent_incomplete, stack_fault_event, stack_overflow, unmasked_exception;
   logic fpu_sync_instr, tag_restore_instr, tag_store_instr, dev_not_avail, internal_fault;
   logic external_fault_request, affine_closure, irq;
   int fails = 0;
   int tests_run = 0;
   always #12.5 clock = ~clock;
   fpu_state_word_control i_fpu_state_word_control
   (
      .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hburst(3'h0),
      .hprot(4'h0), .hmastlock(1'b0), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
      .hresp, .stack_values, .fpu_init_instr, .remainder_incomplete, .partial_tangent_done,
      .partial_tangent_incomplete, .stack_fault_event, .stack_overflow, .unmasked_exception,
      .fpu_sync_instr, .tag_restore_instr, .tag_restore_word, .tag_store_instr,
      .tag_store_word, .dev_not_avail, .internal_fault, .external_fault_request,
      .fault_vector, .affine_closure, .irq
   );
   iu_model i_iu_model
   (
      .clock, .fpu_init_instr, .remainder_incomplete, .partial_tangent_done,
      .stack_fault_event, .unmasked_exception, .fpu_sync_instr, .tag_restore_instr,
      .tag_store_instr, .stack_overflow, .partial_tangent_incomplete, .tag_restore_word
   );
   // ---------------------------------
   // Shared tasks
   // ---------------------------------
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         fails++;
         finish_test();
      end
   endtask : wait_ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      #1;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(what, q, exp);
   endtask : rdc
   // Event pulse, then let the answering edge settle
   task automatic ev(input logic [7:0] e, input logic l = 1'b0, input logic [15:0] w = 16'h0);
      i_iu_model.fire(e, l, w);
      #1;
   endtask : ev
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic t_regs;
      rdc(8'h00, 32'h10, "ctrl zero reset");
      rdc(8'h04, 32'h0, "status reset");
      rdc(8'h08, 32'h037f, "control word reset");
      rdc(8'h0c, 32'hffff, "tag word reset");
      check("resp", hresp, 1'b0);
      check("ready", hreadyout, 1'b1);
      wr(8'h00, 32'h2a);
      rdc(8'h00, 32'h3a, "ctrl zero set");
      wr(8'h00, 32'h0);
      rdc(8'h00, 32'h10, "ctrl zero clear");
      wr(8'h08, 32'h137f);
      rdc(8'h08, 32'h137f, "infinity bit");
      check("affine", affine_closure, 1'b1);
      rdc(8'h40, 32'h0, "unmapped");
      $display("registers done");
   endtask : t_regs
   task automatic t_cond;
      ev(8'h80);
      rdc(8'h04, 32'h0, "after init");
      ev(8'h10, 1'b1);
      rdc(8'h04, 32'h0241, "overflow");
      ev(8'h80);
      rdc(8'h04, 32'h0, "init again");
      ev(8'h10, 1'b0);
      rdc(8'h04, 32'h0041, "underflow");
      ev(8'h20, 1'b1);
      rdc(8'h04, 32'h0441, "tangent incomplete");
      ev(8'h20, 1'b0);
      rdc(8'h04, 32'h0041, "tangent complete");
      ev(8'h10, 1'b1);
      wr(8'h04, 32'h4741);
      ev(8'h40);
      rdc(8'h04, 32'h0441, "remainder incomplete");
      wr(8'h04, 32'h4700);
      ev(8'h80);
      rdc(8'h04, 32'h0, "final init");
      $display("condition flags done");
   endtask : t_cond
   task automatic t_fault;
      wr(8'h14, 32'hf);
      wr(8'h18, 32'hf);
      check("irq idle", irq, 1'b0);
      ev(8'h08);
      check("external", external_fault_request, 1'b1);
      check("not internal", internal_fault, 1'b0);
      check("irq raised", irq, 1'b1);
      wr(8'h10, 32'h0);
      rdc(8'h10, 32'h4, "irq status");
      wr(8'h18, 32'h4);
      check("irq cleared", irq, 1'b0);
      wr(8'h14, 32'h0);
      wr(8'h00, 32'h20);
      ev(8'h08);
      check("internal", internal_fault, 1'b1);
      check("vector 16", fault_vector, 8'h10);
      check("irq masked", irq, 1'b0);
      wr(8'h14, 32'h2);
      check("irq enabled", irq, 1'b1);
      wr(8'h18, 32'hf);
      $display("fault routing done");
   endtask : t_fault
   task automatic t_dna;
      wr(8'h00, 32'h0a);
      ev(8'h04);
      check("trap", dev_not_avail, 1'b1);
      check("vector 7", fault_vector, 8'h07);
      wr(8'h00, 32'h02);
      ev(8'h04);
      check("no trap", dev_not_avail, 1'b0);
      $display("wait trap done");
   endtask : t_dna
   task automatic t_tags;
      ev(8'h02, 1'b0, 16'h924b);
      rdc(8'h0c, 32'h0003, "restored tags");
      ev(8'h01);
      check("stored tags", tag_store_word, 16'h5557);
      stack_values[80+:80] <= {1'b0, 15'h3fff, 64'h0};
      stack_values[160+:80] <= {1'b0, 15'h3fff, 1'b1, 63'h0};
      stack_values[240+:80] <= {1'b0, 15'h0000, 1'b1, 63'h0};
      ev(8'h01);
      check("unnormal tag", tag_store_word, 16'h558b);
      rdc(8'h1c, 32'h558b, "stored word reg");
      ev(8'h80);
      ev(8'h01);
      check("all empty", tag_store_word, 16'hffff);
      $display("tags done");
   endtask : t_tags
   initial
   begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_regs();
      t_cond();
      t_fault();
      t_dna();
      t_tags();
      finish_test();
   end
endmodule : tb_fpu_state_word_control
